// file: test/core_status_option_pc_logic_tb_top.sv
// Purpose: Scenario bench for the status, option and counter block.
// Assumes: Arithmetic flags come out of reset cleared.
// Notes:   Each go() call checks the counter after its edge.
`timescale 1ns/1ps
`default_nettype none
module core_status_option_pc_logic_tb_top;
   logic                    clk_sys = 1'b0;
   logic                    rst_n   = 1'b0;
   logic                    tmo;
   logic [7:0]              rd_addr = 8'h02;
   logic [7:0]              rd_data, status, option;
   logic [10:0]             pc;
   csp_pkg::csp_timer_cfg_t cfg;
   csp_pkg::csp_exec_t      exec, e;
   int                      fail_count = 0;
   int                      checked = 0;
   initial forever #5 clk_sys = ~clk_sys;
   csp_exec_model pm_u (.clk_sys(clk_sys), .exec_o(exec), .timeout_o(tmo));
   csp_core_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .exec_i(exec),
      .watchdog_timeout_i(tmo), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
      .status_o(status), .option_o(option), .pc_o(pc), .timer_cfg_o(cfg));
   task automatic chk(input string n, input logic [10:0] x, input logic [10:0] g);
      checked++;
      if (g !== x)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic go(input logic [10:0] xpc);
      pm_u.issue(e);
      @(posedge clk_sys);
      #1;
      chk("pc", xpc, pc);
      e = '0;
      e.valid = 1'b1;
   endtask : go
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      e.wr_en = 1'b1;
      e.wr_addr = a;
      e.wr_data = d;
   endtask : wr
   task automatic t_reset();
      pm_u.idle();
      rst_n = 1'b0;
      repeat (6) @(negedge clk_sys);
      chk("status", 8'h18, status);
      chk("option", 8'h3F, option);
      chk("pc", 11'h7FF, pc);
      rst_n = 1'b1;
   endtask : t_reset
   task automatic t_seq();
      @(posedge clk_sys);
      #1;
      chk("pc", 11'h7FF, pc);
      go(11'h000);
      e.pc_op = csp_pkg::CSP_PC_JUMP;
      e.target = 9'h1FF;
      go(11'h1FF);
      go(11'h200);
      chk("status", 8'h18, status);
      chk("rd", 8'h00, rd_data);
      e.pc_op = csp_pkg::CSP_PC_JUMP;
      e.target = 9'h0AB;
      go(11'h0AB);
   endtask : t_seq
   task automatic t_status();
      e.sleep = 1'b1;
      go(11'h0AC);
      wr(8'h03, 8'hFF);
      go(11'h0AD);
      chk("status", 8'hF7, status);
      wr(8'h03, 8'h00);
      e.flag_op = csp_pkg::CSP_FLAG_ADD;
      e.opa = 8'h0F;
      e.opb = 8'h01;
      e.result = 8'h10;
      go(11'h0AE);
      chk("status", 8'h12, status);
      wr(8'h03, 8'h00);
      e.flag_op = csp_pkg::CSP_FLAG_ZERO;
      go(11'h0AF);
      pm_u.idle();
      rd_addr = 8'h03;
      @(posedge clk_sys);
      #1;
      chk("rd", 8'h16, rd_data);
      pm_u.idle();
      rd_addr = 8'h02;
   endtask : t_status
   task automatic fl(input csp_pkg::csp_flag_op_t op, input logic [7:0] a, b, r,
                     input logic [2:0] xf, input logic [10:0] xpc);
      e.flag_op = op;
      e.opa = a;
      e.opb = b;
      e.result = r;
      go(xpc);
      chk("flags", xf, status[2:0]);
   endtask : fl
   task automatic opt(input logic [7:0] w, input logic [10:0] xc, input logic [10:0] xpc);
      e.option_load = 1'b1;
      e.work_reg = w;
      go(xpc);
      chk("option", {2'h0, w[5:0]}, option);
      go(xpc + 11'h1);
      chk("cfg", xc, cfg);
   endtask : opt
   task automatic t_pc();
      wr(8'h03, 8'h20);
      go(11'h0BB);
      e.pc_op = csp_pkg::CSP_PC_JUMP;
      e.target = 9'h105;
      go(11'h305);
      wr(8'h02, 8'h34);
      e.pc_op = csp_pkg::CSP_PC_JUMP;
      e.target = 9'h1FF;
      go(11'h234);
      chk("rd", 8'h34, rd_data);
      wr(8'h03, 8'h60);
      go(11'h235);
      e.pc_op = csp_pkg::CSP_PC_LOW_LOAD;
      e.target = 9'h1FF;
      go(11'h6FF);
      wr(8'h02, 8'hFF);
      go(11'h6FF);
      go(11'h700);
   endtask : t_pc
   task automatic t_wdt();
      e.clr_watchdog = 1'b1;
      go(11'h701);
      chk("status", 8'h78, status);
      pm_u.pulse();
      chk("status", 8'h68, status);
      chk("pc", 11'h701, pc);
      e.sleep = 1'b1;
      go(11'h702);
      chk("status", 8'h70, status);
   endtask : t_wdt
   task automatic give_verdict();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      e = '0;
      e.valid = 1'b1;
      t_reset();
      t_seq();
      t_status();
      fl(csp_pkg::CSP_FLAG_ADD, 8'hFF, 8'h01, 8'h00, 3'h7, 11'h0B0);
      fl(csp_pkg::CSP_FLAG_ROT_L, 8'h7F, 8'h00, 8'hFE, 3'h6, 11'h0B1);
      fl(csp_pkg::CSP_FLAG_ROT_R, 8'h01, 8'h00, 8'h00, 3'h7, 11'h0B2);
      fl(csp_pkg::CSP_FLAG_SUB, 8'h10, 8'h01, 8'h0F, 3'h1, 11'h0B3);
      fl(csp_pkg::CSP_FLAG_SUB, 8'h05, 8'h05, 8'h00, 3'h7, 11'h0B4);
      opt(8'hC5, 11'h065, 11'h0B5);
      opt(8'h3A, 11'h732, 11'h0B7);
      opt(8'h07, 11'h087, 11'h0B9);
      t_pc();
      t_wdt();
      t_reset();
      give_verdict();
   end
   initial
   begin
      #5000;
      fail_count++;
      give_verdict();
   end
endmodule : core_status_option_pc_logic_tb_top
`default_nettype wire

// file: test/csp_core_regs_props.sv
// Purpose: Port assertions for the status, option and counter block.
// Assumes: Outputs except timer_cfg_o show the state after the edge that took the request.
// Notes:   Bound to every csp_core_regs instance.
`timescale 1ns/1ps
`default_nettype none
module csp_core_regs_props (
   // Clock and reset
   input wire logic                      clk_sys,
   input wire logic                      rst_n,
   // Watched ports
   input wire csp_pkg::csp_exec_t        exec_i,
   input wire logic                      watchdog_timeout_i,
   input wire logic [7:0]                rd_addr_i,
   input wire logic [7:0]                rd_data_o,
   input wire logic [7:0]                status_o,
   input wire logic [7:0]                option_o,
   input wire logic [csp_pkg::PC_W-1:0]  pc_o,
   input wire csp_pkg::csp_timer_cfg_t   timer_cfg_o
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire v     = exec_i.valid;
   wire st_wr = v && exec_i.wr_en && exec_i.wr_addr == 8'h03;
   wire pl_wr = v && exec_i.wr_en && exec_i.wr_addr == 8'h02;
   wire no_fl = !v || exec_i.flag_op == csp_pkg::CSP_FLAG_NONE;
   wire ev    = v && (exec_i.clr_watchdog || exec_i.sleep) || watchdog_timeout_i;
   property p_keep; no_fl && !st_wr |=> $stable(status_o[2:0]); endproperty
   a_keep: assert property (p_keep) else $error("flags moved");
   property p_ro; st_wr && !ev |=> status_o[4:3] == $past(status_o[4:3]); endproperty
   a_ro: assert property (p_ro) else $error("reset flags written");
   property p_tmo; watchdog_timeout_i |=> !status_o[4]; endproperty
   a_tmo: assert property (p_tmo) else $error("timeout flag set");
   property p_opt;
      v && exec_i.option_load |=> option_o == {2'h0, $past(exec_i.work_reg[5:0])};
   endproperty
   a_opt: assert property (p_opt) else $error("option load");
   property p_cfg;
      timer_cfg_o == {$past(option_o[5:3]), 4'h1 + $past(option_o[2:0]), 1'h0,
                      $past(option_o[2:0])};
   endproperty
   a_cfg: assert property (p_cfg) else $error("timer config");
   property p_seq;
      v && exec_i.pc_op == csp_pkg::CSP_PC_SEQ && !pl_wr |=> pc_o == $past(pc_o) + 11'h1;
   endproperty
   a_seq: assert property (p_seq) else $error("pc step");
   property p_jmp;
      v && exec_i.pc_op == csp_pkg::CSP_PC_JUMP && !pl_wr && !st_wr
         |=> pc_o == {$past(status_o[6:5]), $past(exec_i.target)};
   endproperty
   a_jmp: assert property (p_jmp) else $error("jump load");
   property p_low; pl_wr |=> pc_o == {$past(status_o[6:5]), 1'h0, $past(exec_i.wr_data)};
   endproperty
   a_low: assert property (p_low) else $error("low byte load");
   property p_call;
      v && exec_i.pc_op == csp_pkg::CSP_PC_LOW_LOAD && !pl_wr
         |=> pc_o == {$past(status_o[6:5]), 1'h0, $past(exec_i.target[7:0])};
   endproperty
   a_call: assert property (p_call) else $error("call load");
   property p_lock;
      st_wr && exec_i.flag_op == csp_pkg::CSP_FLAG_ZERO |=> status_o[1:0] == $past(status_o[1:0]);
   endproperty
   a_lock: assert property (p_lock) else $error("locked flags written");
   property p_rd; rd_addr_i == 8'h02 |=> rd_data_o == pc_o[7:0]; endproperty
   a_rd: assert property (p_rd) else $error("low byte read");
endmodule : csp_core_regs_props
bind csp_core_regs csp_core_regs_props cp_u (.clk_sys(clk_sys), .rst_n(rst_n),
   .exec_i(exec_i), .watchdog_timeout_i(watchdog_timeout_i), .rd_addr_i(rd_addr_i),
   .rd_data_o(rd_data_o), .status_o(status_o), .option_o(option_o), .pc_o(pc_o),
   .timer_cfg_o(timer_cfg_o));
`default_nettype wire

// file: test/csp_exec_model.sv
// Purpose: Execution logic that feeds instructions to the register block.
// Assumes: Requests change at the falling edge and are taken at the rising one.
// Notes:   When idle valid is low and every other field shows the inverse of its previous value.
`timescale 1ns/1ps
`default_nettype none
module csp_exec_model (
   // Clock
   input  wire logic               clk_sys,
   // Requests
   output var  csp_pkg::csp_exec_t exec_o,
   output var  logic               timeout_o
);
   initial exec_o = '0;
   initial timeout_o = 1'b0;
   task automatic issue(input csp_pkg::csp_exec_t e);
      @(negedge clk_sys);
      exec_o = e;
   endtask : issue
   task automatic idle();
      @(negedge clk_sys);
      exec_o = {1'b0, ~exec_o[$bits(exec_o)-2:0]};
   endtask : idle
   task automatic pulse();
      idle();
      timeout_o = 1'b1;
      @(negedge clk_sys);
      timeout_o = 1'b0;
   endtask : pulse
endmodule : csp_exec_model
`default_nettype wire

// file: verilog/csp_core_regs.sv
// Purpose: Status register, option register and program counter of the core.
// Assumes: Flag operands come from the ALU; watchdog timeout is a same-clock pulse.
// Notes:   All outputs are registered.
`timescale 1ns/1ps
`default_nettype none
module csp_core_regs (
   // Clock and reset
   input  wire  logic                     clk_sys,
   input  wire  logic                     rst_n,
   // Execution request
   input  wire  csp_pkg::csp_exec_t       exec_i,
   input  wire  logic                     watchdog_timeout_i,
   input  wire  logic [7:0]               rd_addr_i,
   // Results
   output logic [7:0]                     rd_data_o,
   output logic [7:0]                     status_o,
   output logic [7:0]                     option_o,
   output logic [csp_pkg::PC_W-1:0]       pc_o,
   output csp_pkg::csp_timer_cfg_t        timer_cfg_o
);

   logic [7:0]                 status_q;
   logic [7:0]                 status_d;
   logic [5:0]                 option_q;
   logic [5:0]                 option_d;
   logic [csp_pkg::PC_W-1:0]   pc_q;
   logic [csp_pkg::PC_W-1:0]   pc_d;
   logic [7:0]                 rd_data_d;
   logic [8:0]                 sum9;
   logic [4:0]                 sum5;
   logic                       stat_wr;
   logic                       low_wr;

   assign stat_wr = exec_i.valid && exec_i.wr_en && exec_i.wr_addr == csp_pkg::STATUS_ADDR;
   assign low_wr  = exec_i.valid && exec_i.wr_en && exec_i.wr_addr == csp_pkg::PC_LOW_ADDR;

   // Status next value
   always_comb
   begin
      status_d = status_q;
      sum9     = 9'h000;
      sum5     = 5'h00;
      if (stat_wr)
      begin
         status_d[7:5] = exec_i.wr_data[7:5];
      end
      // Any flag-affecting op locks all three arithmetic flags against the write
      if (stat_wr && exec_i.flag_op == csp_pkg::CSP_FLAG_NONE)
      begin
         status_d[2:0] = exec_i.wr_data[2:0];
      end
      if (exec_i.valid)
      begin
         case (exec_i.flag_op)
            csp_pkg::CSP_FLAG_ADD:
            begin
               sum9 = {1'b0, exec_i.opa} + {1'b0, exec_i.opb};
               sum5 = {1'b0, exec_i.opa[3:0]} + {1'b0, exec_i.opb[3:0]};
               status_d[csp_pkg::BIT_CARRY] = sum9[8];
               status_d[csp_pkg::BIT_HALF]  = sum5[4];
               status_d[csp_pkg::BIT_ZERO]  = exec_i.result == 8'h00;
            end
            csp_pkg::CSP_FLAG_SUB:
            begin
               // opa minus opb, carry is inverted borrow
               sum9 = {1'b0, exec_i.opa} + {1'b0, ~exec_i.opb} + 9'h001;
               sum5 = {1'b0, exec_i.opa[3:0]} + {1'b0, ~exec_i.opb[3:0]} + 5'h01;
               status_d[csp_pkg::BIT_CARRY] = sum9[8];
               status_d[csp_pkg::BIT_HALF]  = sum5[4];
               status_d[csp_pkg::BIT_ZERO]  = exec_i.result == 8'h00;
            end
            csp_pkg::CSP_FLAG_ZERO:
            begin
               status_d[csp_pkg::BIT_ZERO] = exec_i.result == 8'h00;
            end
            csp_pkg::CSP_FLAG_ROT_R:
            begin
               status_d[csp_pkg::BIT_CARRY] = exec_i.opa[0];
            end
            csp_pkg::CSP_FLAG_ROT_L:
            begin
               status_d[csp_pkg::BIT_CARRY] = exec_i.opa[7];
            end
            default:
            begin
               status_d = status_d;
            end
         endcase
      end
      // Reset-status flags follow only their hardware events
      if (exec_i.valid && exec_i.clr_watchdog)
      begin
         status_d[csp_pkg::BIT_TO] = 1'b1;
         status_d[csp_pkg::BIT_PD] = 1'b1;
      end
      else if (exec_i.valid && exec_i.sleep)
      begin
         status_d[csp_pkg::BIT_TO] = 1'b1;
         status_d[csp_pkg::BIT_PD] = 1'b0;
      end
      // Timeout is applied last so it is never lost
      if (watchdog_timeout_i)
      begin
         status_d[csp_pkg::BIT_TO] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Arithmetic flags have no defined reset value; zero chosen
         status_q <= csp_pkg::STATUS_RESET;
      end
      else
      begin
         status_q <= status_d;
      end
   end

   // Option register next value, shown on option_o at the loading edge
   always_comb
   begin
      option_d = option_q;
      if (exec_i.valid && exec_i.option_load)
      begin
         option_d = exec_i.work_reg[5:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         option_q <= csp_pkg::OPTION_RESET;
      end
      else
      begin
         option_q <= option_d;
      end
   end

   // Program counter
   always_comb
   begin
      pc_d = pc_q + 11'h001;
      if (exec_i.valid)
      begin
         case (exec_i.pc_op)
            csp_pkg::CSP_PC_JUMP:
            begin
               pc_d = {status_q[6:5], exec_i.target};
            end
            csp_pkg::CSP_PC_LOW_LOAD:
            begin
               pc_d = {status_q[6:5], 1'b0, exec_i.target[7:0]};
            end
            default:
            begin
               pc_d = pc_q + 11'h001;
            end
         endcase
         if (low_wr)
         begin
            pc_d = {status_q[6:5], 1'b0, exec_i.wr_data};
         end
      end
      else
      begin
         pc_d = pc_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pc_q <= csp_pkg::PC_RESET;
      end
      else
      begin
         pc_q <= pc_d;
      end
   end

   // File read port
   always_comb
   begin
      if (rd_addr_i == csp_pkg::STATUS_ADDR)
      begin
         rd_data_d = status_d;
      end
      else if (rd_addr_i == csp_pkg::PC_LOW_ADDR)
      begin
         rd_data_d = pc_d[7:0];
      end
      else
      begin
         rd_data_d = 8'h00;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_data_o <= 8'h00;
      end
      else
      begin
         rd_data_o <= rd_data_d;
      end
   end

   // Registered copies and decoded timer controls
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_o    <= csp_pkg::STATUS_RESET;
         option_o    <= {2'b00, csp_pkg::OPTION_RESET};
         pc_o        <= csp_pkg::PC_RESET;
         timer_cfg_o <= '{ext_clock:      csp_pkg::OPTION_RESET[csp_pkg::OPT_CS],
                           falling_edge:   csp_pkg::OPTION_RESET[csp_pkg::OPT_SE],
                           to_watchdog:    csp_pkg::OPTION_RESET[csp_pkg::OPT_PSA],
                           timer_log2_div: {1'b0, csp_pkg::OPTION_RESET[2:0]} + 4'h1,
                           wdt_log2_div:   {1'b0, csp_pkg::OPTION_RESET[2:0]}};
      end
      else
      begin
         status_o                   <= status_d;
         option_o                   <= {2'b00, option_d};
         pc_o                       <= pc_d;
         timer_cfg_o.ext_clock      <= option_q[csp_pkg::OPT_CS];
         timer_cfg_o.falling_edge   <= option_q[csp_pkg::OPT_SE];
         timer_cfg_o.to_watchdog    <= option_q[csp_pkg::OPT_PSA];
         timer_cfg_o.timer_log2_div <= {1'b0, option_q[2:0]} + 4'h1;
         timer_cfg_o.wdt_log2_div   <= {1'b0, option_q[2:0]};
      end
   end

endmodule : csp_core_regs
`default_nettype wire

// file: verilog/csp_pkg.sv
// Purpose: Constants and types for the core status, option and program counter block.
// Assumes: Core executes one instruction per clk_sys edge when its execute strobe is high.
// Notes:   How it works list follows.
// How it works
// - Status destination with flag-affecting op: writes to Z, DC, C are disabled.
// - Timeout and power-down flags ignore every register write.
// - Bit clear, bit set, move and swap leave Z, DC, C alone.
// - Status bit 7 is reserved read/write, resets to 0.
// - Status bits 6-5 select one of four 512-word program pages.
// - Timeout flag resets 1, set by clear-watchdog or sleep, cleared by timeout.
// - Power-down flag resets 1, set by clear-watchdog, cleared by sleep.
// - Zero flag set when an affecting result is zero, else cleared.
// - Half-carry set on low-nibble carry for add, on no borrow for subtract.
// - Carry from add carry, subtract no-borrow, rotate right lsb, rotate left msb.
// - Option register is 6-bit write-only, loaded from working register.
// - Any reset sets all six option bits to 1.
// - Option bits 7-6 are unimplemented and read zero.
// - Option bit 5 picks external pin (1) or instruction clock (0) for timer.
// - Option bit 4 picks falling (1) or rising (0) pin edge.
// - Option bit 3 gives prescaler to watchdog (1) or timer (0).
// - Option bits 2-0 give timer ratio 2^(n+1), watchdog ratio 2^n.
// - Program counter holds next address, increments each cycle unless changed.
// - Jump loads counter bits 8:0 from the instruction target field.
// - Jump, call and computed jump load counter bits 10:9 from page select.
// - Call or low-byte write loads bits 7:0, forces bit 8 to zero.
// - Low counter byte is readable as a file register at counter bits 7:0.
// - Reset clears page select and sets counter to last location of last page.
// - Sequential increment crosses pages without updating page select.
package csp_pkg;

   localparam logic [7:0]  STATUS_ADDR      = 8'h03;
   localparam logic [7:0]  PC_LOW_ADDR      = 8'h02;
   localparam int          PC_W             = 11;
   localparam logic [10:0] PC_RESET         = 11'h7FF;
   localparam logic [5:0]  OPTION_RESET     = 6'h3F;
   localparam logic [2:0]  STATUS_TOP_RESET = 3'h0;
   // Page bits clear, timeout and power-down set, arithmetic flags cleared
   localparam logic [7:0]  STATUS_RESET     = 8'h18;
   localparam int          BIT_CARRY        = 0;
   localparam int          BIT_HALF         = 1;
   localparam int          BIT_ZERO         = 2;
   localparam int          BIT_PD           = 3;
   localparam int          BIT_TO           = 4;
   localparam int          BIT_PAGE_LO      = 5;
   localparam int          BIT_RSV          = 7;
   localparam int          OPT_CS           = 5;
   localparam int          OPT_SE           = 4;
   localparam int          OPT_PSA          = 3;

   // Kind of flag update requested by the executing instruction
   typedef enum logic [2:0] {
      CSP_FLAG_NONE,
      CSP_FLAG_ADD,
      CSP_FLAG_SUB,
      CSP_FLAG_ZERO,
      CSP_FLAG_ROT_R,
      CSP_FLAG_ROT_L
   } csp_flag_op_t;

   // Kind of program counter change
   typedef enum logic [1:0] {
      CSP_PC_SEQ,
      CSP_PC_JUMP,
      CSP_PC_LOW_LOAD
   } csp_pc_op_t;

   // One instruction's request from the execution logic
   typedef struct packed {
      logic         valid;
      csp_flag_op_t flag_op;
      logic [7:0]   opa;
      logic [7:0]   opb;
      logic [7:0]   result;
      logic         wr_en;
      logic [7:0]   wr_addr;
      logic [7:0]   wr_data;
      logic         option_load;
      logic [7:0]   work_reg;
      csp_pc_op_t   pc_op;
      logic [8:0]   target;
      logic         clr_watchdog;
      logic         sleep;
   } csp_exec_t;

   // Timer and prescaler controls decoded from the option register
   typedef struct packed {
      logic       ext_clock;
      logic       falling_edge;
      logic       to_watchdog;
      logic [3:0] timer_log2_div;
      logic [3:0] wdt_log2_div;
   } csp_timer_cfg_t;

endpackage : csp_pkg
